// file: rtl/pdm_pin_mux.sv
`timescale 1ns/10ps
// Behaviour
// - Memory bus drives pins 5,6 first
// - Memory bus drives pin 7 first
// - Memory read cycles capture pins 5-7
// - Parallel read drives latch bits out
// - Parallel write data taken from pins
// - Direction ignored under memory/parallel ownership
// - SPI data input on pin 5
// - SPI clock on pin 6 by direction
// - Two-wire outputs beat parallel and port
// - Two-wire input type follows configuration
// - Pin 7 gives slave select input
module pdm_pin_mux
  import pdm_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [DATA_W-1:0]  pwdata,
  output logic [DATA_W-1:0]       prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [PIN_CNT-1:0] pinIn,
  output logic [PIN_CNT-1:0]      pinOut,
  output logic [PIN_CNT-1:0]      pinOeN,
  output pdm_intype_type          pinInType [PIN_CNT],
  input  wire logic [PIN_CNT-1:0] memAddrDataOut,
  input  wire logic               memDriveBus,
  input  wire logic               memReadCycle,
  output logic [PIN_CNT-1:0]      memDataIn,
  input  wire logic               pspReadStrobe,
  input  wire logic               pspWriteStrobe,
  output logic [PIN_CNT-1:0]      pspWriteData,
  input  wire logic               spiClockOut,
  input  wire logic               twoWireDataOut,
  input  wire logic               twoWireClockOut,
  output logic                    serialDataIn,
  output logic                    serialClockIn,
  output logic                    twoWireDataIn,
  output logic                    twoWireClockIn,
  output logic                    slaveSelectInN
);

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  logic [PORT_W-1:0]  latch_q;
  logic [PORT_W-1:0]  dir_q;
  logic [CTRL_W-1:0]  ctrl_q;
  logic [PIN_CNT-1:0] pinSample_q;
  logic               pready_q;
  logic [DATA_W-1:0]  prdata_q;
  logic               pslverr_q;
  logic [PIN_CNT-1:0] pinOut_q;
  logic [PIN_CNT-1:0] pinOeN_q;
  pdm_intype_type     inType_q [PIN_CNT];
  pdm_intype_type     inType_d [PIN_CNT];
  logic [PIN_CNT-1:0] memDataIn_q;
  logic [PIN_CNT-1:0] pspWriteData_q;
  logic               serialDataIn_q;
  logic               serialClockIn_q;
  logic               twoWireDataIn_q;
  logic               twoWireClockIn_q;
  logic               slaveSelectInN_q;

  // --------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------
  wire logic              setupPhase;
  wire logic              accessDone;
  wire logic              writeDone;
  wire logic              hitPin;
  wire logic              hitLatch;
  wire logic              hitDir;
  wire logic              hitCtrl;
  wire logic              hitOwner;
  wire logic              hitAny;
  wire logic [DATA_W-1:0] readWord;
  wire logic [5:0]        ownerWord;

  assign setupPhase = psel & ~penable;
  assign accessDone = psel & penable & pready_q;
  assign writeDone  = accessDone & pwrite;
  assign hitPin     = (paddr == REG_PIN_VALUE);
  assign hitLatch   = (paddr == REG_LATCH);
  assign hitDir     = (paddr == REG_DIRECTION);
  assign hitCtrl    = (paddr == REG_CONTROL);
  assign hitOwner   = (paddr == REG_OWNER);
  assign hitAny     = hitPin | hitLatch | hitDir | hitCtrl | hitOwner;

  // Lower pins live elsewhere, so their value reads back from the latch
  assign readWord =
    hitPin   ? {24'h000000, pinSample_q, latch_q[FIRST_PIN-1:0]} :
    hitLatch ? {24'h000000, latch_q} :
    hitDir   ? {24'h000000, dir_q} :
    hitCtrl  ? {27'h0000000, ctrl_q} :
    hitOwner ? {26'h0000000, ownerWord} :
               32'h00000000;

  // --------------------------------------------------------------
  // Mode decode
  // --------------------------------------------------------------
  wire logic               memEn;
  wire logic               pspEn;
  wire logic               serEn;
  wire logic               spiMode;
  wire logic               i2cMode;
  wire logic [PIN_CNT-1:0] serOwn;
  wire logic [PIN_CNT-1:0] serBit;
  wire logic [PIN_CNT-1:0] serOd;
  wire logic [PIN_CNT-1:0] cellOut;
  wire logic [PIN_CNT-1:0] cellOeN;
  wire logic [PIN_CNT-1:0] dirHi;
  pdm_owner_type           owner [PIN_CNT];

  assign memEn   = ctrl_q[CTRL_MEM_EN];
  assign pspEn   = ctrl_q[CTRL_PSP_EN];
  assign serEn   = ctrl_q[CTRL_SER_EN];
  assign spiMode = serEn & ~ctrl_q[CTRL_SER_I2C];
  assign i2cMode = serEn & ctrl_q[CTRL_SER_I2C];
  assign dirHi   = dir_q[PORT_W-1:FIRST_PIN];

  // Serial owns a pin only while it has something to drive
  assign serOwn = {1'b0, i2cMode | (spiMode & ~dirHi[1]), i2cMode};
  assign serBit = {1'b1, i2cMode ? twoWireClockOut : spiClockOut,
                   twoWireDataOut};
  assign serOd  = {1'b1, i2cMode, 1'b1};

  assign ownerWord = {owner[2], owner[1], owner[0]};

  // --------------------------------------------------------------
  // Pin cells
  // --------------------------------------------------------------
  for (genvar i = 0; i < PIN_CNT; i++) begin : g_pin
    assign owner[i] = pdm_pick_owner(memEn, serOwn[i], pspEn);
    pdm_pin_cell u_cell (
      .owner        (owner[i]),
      .memBit       (memAddrDataOut[i]),
      .memDrive     (memDriveBus),
      .serBit       (serBit[i]),
      .serOpenDrain (serOd[i]),
      .pspRead      (pspReadStrobe),
      .latchBit     (latch_q[FIRST_PIN+i]),
      .dirBit       (dirHi[i]),
      .outBit       (cellOut[i]),
      .oeN          (cellOeN[i])
    );
  end

  // --------------------------------------------------------------
  // Input buffer type
  // --------------------------------------------------------------
  // Level choice only; the pad itself is outside this block
  always_comb begin
    for (int i = 0; i < PIN_CNT; i++) begin
      inType_d[i] = IN_SCHMITT;
      if (memEn || pspEn) begin
        inType_d[i] = IN_TTL;
      end
    end
    if (i2cMode && !memEn) begin
      inType_d[0] = ctrl_q[CTRL_I2C_SMB] ? IN_SMB : IN_I2C;
      inType_d[1] = ctrl_q[CTRL_I2C_SMB] ? IN_SMB : IN_I2C;
    end
    if (spiMode && dirHi[2] && !memEn) begin
      inType_d[2] = IN_TTL;
    end
  end

  // --------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      latch_q <= LATCH_RESET;
      dir_q   <= DIR_RESET;
      ctrl_q  <= CTRL_RESET;
    end else if (writeDone) begin
      if (hitPin || hitLatch) begin
        latch_q <= pwdata[PORT_W-1:0];
      end
      if (hitDir) begin
        dir_q <= pwdata[PORT_W-1:0];
      end
      if (hitCtrl) begin
        ctrl_q <= pwdata[CTRL_W-1:0];
      end
    end
  end

  // Answer prepared in setup, so every access takes one wait-free cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setupPhase;
      prdata_q  <= setupPhase ? readWord : prdata_q;
      pslverr_q <= setupPhase & ~hitAny;
    end
  end

  // --------------------------------------------------------------
  // Pin and engine side
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      pinOut_q    <= 3'h0;
      pinOeN_q    <= 3'h7;
      pinSample_q <= 3'h0;
      inType_q    <= '{default: IN_SCHMITT};
    end else begin
      pinOut_q    <= cellOut;
      pinOeN_q    <= cellOeN;
      pinSample_q <= pinIn;
      inType_q    <= inType_d;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      memDataIn_q    <= 3'h0;
      pspWriteData_q <= 3'h0;
    end else begin
      if (memEn && memReadCycle) begin
        memDataIn_q <= pinIn;
      end
      if (pspEn && !memEn && pspWriteStrobe) begin
        pspWriteData_q <= pinIn;
      end
    end
  end

  // Inputs park at idle levels when not routed to the serial engine
  always_ff @(posedge clk) begin
    if (reset) begin
      serialDataIn_q   <= 1'b0;
      serialClockIn_q  <= 1'b0;
      twoWireDataIn_q  <= 1'b1;
      twoWireClockIn_q <= 1'b1;
      slaveSelectInN_q <= 1'b1;
    end else begin
      serialDataIn_q   <= (spiMode && dirHi[0]) ? pinIn[0] : 1'b0;
      serialClockIn_q  <= (spiMode && dirHi[1]) ? pinIn[1] : 1'b0;
      twoWireDataIn_q  <= i2cMode ? pinIn[0] : 1'b1;
      twoWireClockIn_q <= i2cMode ? pinIn[1] : 1'b1;
      slaveSelectInN_q <= (spiMode && dirHi[2]) ? pinIn[2] : 1'b1;
    end
  end

  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign pinOut         = pinOut_q;
  assign pinOeN         = pinOeN_q;
  assign pinInType      = inType_q;
  assign memDataIn      = memDataIn_q;
  assign pspWriteData   = pspWriteData_q;
  assign serialDataIn   = serialDataIn_q;
  assign serialClockIn  = serialClockIn_q;
  assign twoWireDataIn  = twoWireDataIn_q;
  assign twoWireClockIn = twoWireClockIn_q;
  assign slaveSelectInN = slaveSelectInN_q;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_latch_write;
    psel && penable && pready && pwrite && (paddr == REG_LATCH);
  endsequence

  a_mem_low_pins: assert property (
    memEn && memDriveBus |=> pinOut[1:0] == $past(memAddrDataOut[1:0])
                             && pinOeN[1:0] == 2'b00)
    else $error("memory bus lost pins 5 or 6");

  a_mem_pin_seven: assert property (
    memEn && memDriveBus |=> pinOut[2] == $past(memAddrDataOut[2])
                             && !pinOeN[2])
    else $error("memory bus lost pin 7");

  a_mem_read_capture: assert property (
    memEn && memReadCycle |=> memDataIn == $past(pinIn))
    else $error("memory read data not captured");

  a_psp_read_drive: assert property (
    !memEn && pspEn && pspReadStrobe
      |=> pinOut[2] == $past(latch_q[7]) && !pinOeN[2])
    else $error("parallel read not driving latch");

  a_psp_write_data: assert property (
    !memEn && pspEn && pspWriteStrobe |=> pspWriteData == $past(pinIn))
    else $error("parallel write data not taken");

  a_dir_ignored: assert property (
    memEn && !memDriveBus && dir_q == 8'h00 |=> pinOeN == 3'h7)
    else $error("direction bit acted under ownership");

  a_spi_data_in: assert property (
    spiMode && dirHi[0] |=> serialDataIn == $past(pinIn[0]))
    else $error("serial data input not routed");

  a_spi_clock_out: assert property (
    !memEn && spiMode && !dirHi[1]
      |=> pinOut[1] == $past(spiClockOut) && !pinOeN[1])
    else $error("serial clock not driven");

  a_i2c_data_low: assert property (
    !memEn && i2cMode && !twoWireDataOut |=> !pinOut[0] && !pinOeN[0])
    else $error("two-wire data low not driven");

  a_i2c_in_type: assert property (
    !memEn && i2cMode |=> pinInType[1] ==
      ($past(ctrl_q[CTRL_I2C_SMB]) ? IN_SMB : IN_I2C))
    else $error("two-wire input type wrong");

  a_slave_select: assert property (
    spiMode && dirHi[2] |=> slaveSelectInN == $past(pinIn[2]))
    else $error("slave select not routed");

  a_port_drive: assert property (
    ctrl_q == 5'h00 && !dirHi[2] ##1 ctrl_q == 5'h00 && !dirHi[2]
      |=> pinOut[2] == $past(latch_q[7]) && !pinOeN[2])
    else $error("free pin not driving latch");

  a_latch_write: assert property (
    s_latch_write |=> latch_q == $past(pwdata[7:0]))
    else $error("latch write lost");

  a_apb_ready: assert property (
    s_setup ##1 (psel && penable) |-> pready)
    else $error("access phase without ready");

endmodule // pdm_pin_mux

// file: rtl/pdm_pkg.sv
package pdm_pkg;

  // --------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------
  localparam int          ADDR_W         = 12;
  localparam int          DATA_W         = 32;
  localparam int          PORT_W         = 8;
  localparam int          PIN_CNT        = 3;
  localparam int          FIRST_PIN      = 5;
  localparam int          CTRL_W         = 5;
  localparam logic [11:0] REG_PIN_VALUE  = 12'h000;
  localparam logic [11:0] REG_LATCH      = 12'h004;
  localparam logic [11:0] REG_DIRECTION  = 12'h008;
  localparam logic [11:0] REG_CONTROL    = 12'h00C;
  localparam logic [11:0] REG_OWNER      = 12'h010;

  // --------------------------------------------------------------
  // Reset values and control fields
  // --------------------------------------------------------------
  localparam logic [7:0]  LATCH_RESET    = 8'h00;
  localparam logic [7:0]  DIR_RESET      = 8'hFF;
  localparam logic [4:0]  CTRL_RESET     = 5'h00;
  localparam int          CTRL_MEM_EN    = 0;
  localparam int          CTRL_PSP_EN    = 1;
  localparam int          CTRL_SER_EN    = 2;
  localparam int          CTRL_SER_I2C   = 3;
  localparam int          CTRL_I2C_SMB   = 4;

  // --------------------------------------------------------------
  // Types
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    OWN_PORT,
    OWN_MEM,
    OWN_PSP,
    OWN_SERIAL
  } pdm_owner_type;

  typedef enum logic [1:0] {
    IN_SCHMITT,
    IN_TTL,
    IN_I2C,
    IN_SMB
  } pdm_intype_type;

  // Memory bus first, then serial, then parallel port
  function automatic pdm_owner_type pdm_pick_owner(input logic mem,
                                                   input logic ser,
                                                   input logic parallel_slave_port);
    pdm_owner_type o;
    o = OWN_PORT;
    if (mem) begin
      o = OWN_MEM;
    end else if (ser) begin
      o = OWN_SERIAL;
    end else if (parallel_slave_port) begin
      o = OWN_PSP;
    end
    return o;
  endfunction

endpackage

// file: rtl/pdm_pin_cell.sv
`timescale 1ns/10ps
module pdm_pin_cell
  import pdm_pkg::*;
(
  input  pdm_owner_type owner,
  input  wire logic     memBit,
  input  wire logic     memDrive,
  input  wire logic     serBit,
  input  wire logic     serOpenDrain,
  input  wire logic     pspRead,
  input  wire logic     latchBit,
  input  wire logic     dirBit,
  output logic          outBit,
  output logic          oeN
);

  // ----------------------------------------------------------
  // Per-pin driver selection
  // ----------------------------------------------------------
  // Owned pins ignore the direction bit
  always_comb begin
    outBit = latchBit;
    oeN    = 1'b1;
    case (owner)
      OWN_MEM: begin
        outBit = memBit;
        oeN    = ~memDrive;
      end
      OWN_SERIAL: begin
        // Open drain only pulls low, never drives high
        outBit = serBit;
        oeN    = serOpenDrain ? serBit : 1'b0;
      end
      OWN_PSP: begin
        outBit = latchBit;
        oeN    = ~pspRead;
      end
      OWN_PORT: begin
        outBit = latchBit;
        oeN    = dirBit;
      end
      default: begin
        outBit = latchBit;
        oeN    = 1'b1;
      end
    endcase
  end

endmodule // pdm_pin_cell

// file: testbench/pdm_pin_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Pin wires seen from outside: design drive, external drive, float
// ----------------------------------------------------------------
module pdm_pin_model
  import pdm_pkg::*;
(
  input  wire logic               clk,
  input  wire logic [PIN_CNT-1:0] pinOut,
  input  wire logic [PIN_CNT-1:0] pinOeN,
  input  wire logic [PIN_CNT-1:0] extEn,
  input  wire logic [PIN_CNT-1:0] extVal,
  output logic [PIN_CNT-1:0]      pinIn
);
  logic [PIN_CNT-1:0] lastQ = '0;

  // Floating pin flips each cycle, so a stale level never reads as valid
  always_comb begin
    for (int i = 0; i < PIN_CNT; i++) begin
      if (pinOeN[i] === 1'b0) begin
        pinIn[i] = pinOut[i];
      end else if (extEn[i]) begin
        pinIn[i] = extVal[i];
      end else begin
        pinIn[i] = ~lastQ[i];
      end
    end
  end

  always @(posedge clk) begin
    lastQ <= pinIn;
  end
endmodule // pdm_pin_model

// file: testbench/pdm_pin_mux_test.sv
`timescale 1ns/10ps
`define CHECK(g, e) begin checkCount++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module pdm_pin_mux_test;
  import pdm_pkg::*;
  logic                clk = 0;
  logic                reset = 1;
  logic                psel = 0, penable = 0, pwrite = 0;
  logic [ADDR_W-1:0]   paddr = '0;
  logic [DATA_W-1:0]   pwdata = '0, prdata;
  logic                pready, pslverr;
  logic [PIN_CNT-1:0]  pinIn, pinOut, pinOeN, memDataIn, pspWriteData;
  logic [PIN_CNT-1:0]  memAd = '0, extEn = '0, extVal = '0;
  pdm_intype_type      pinInType [PIN_CNT];
  logic                memDrv = 0, memRd = 0, pspRd = 0, pspWr = 0;
  logic                spiClk = 0, twData = 1, twClk = 1;
  logic                serialDataIn, serialClockIn, twoWireDataIn, twoWireClockIn;
  logic                slaveSelectInN;
  int                  mismatches = 0;
  int                  checkCount = 0;

  pdm_pin_mux i_pdm_pin_mux (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOeN(pinOeN),
    .pinInType(pinInType), .memAddrDataOut(memAd), .memDriveBus(memDrv),
    .memReadCycle(memRd), .memDataIn(memDataIn), .pspReadStrobe(pspRd),
    .pspWriteStrobe(pspWr), .pspWriteData(pspWriteData), .spiClockOut(spiClk),
    .twoWireDataOut(twData), .twoWireClockOut(twClk), .serialDataIn(serialDataIn),
    .serialClockIn(serialClockIn), .twoWireDataIn(twoWireDataIn),
    .twoWireClockIn(twoWireClockIn), .slaveSelectInN(slaveSelectInN));

  pdm_pin_model i_pdm_pin_model (
    .clk(clk), .pinOut(pinOut), .pinOeN(pinOeN), .extEn(extEn), .extVal(extVal),
    .pinIn(pinIn));

  // ----------------------------------------------------------------
  // Bus and helper tasks
  // ----------------------------------------------------------------
  initial begin
    forever #10 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // No fixed latency assumed: a lost pready is left to the watchdog
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1, a, d, r, e);
    `CHECK(e, 1'b0)
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(0, a, 32'h0, r, e);
    `CHECK(r, x)
    `CHECK(e, xe)
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    `CHECK(pinOeN, 3'b111)
    rdchk(REG_LATCH, 32'h00, 0);
    rdchk(REG_DIRECTION, 32'hFF, 0);
    rdchk(REG_CONTROL, 32'h00, 0);
    rdchk(12'h020, 32'h0, 1);
    $display("test reset done");
  endtask

  task automatic t_port();
    wr(REG_PIN_VALUE, 32'h000000C0);
    rdchk(REG_LATCH, 32'hC0, 0);
    wr(REG_LATCH, 32'hFFFFFFA0);
    rdchk(REG_LATCH, 32'hA0, 0);
    wr(REG_DIRECTION, 32'h1F);
    tick(3);
    `CHECK(pinOut, 3'b101)
    `CHECK(pinOeN, 3'b000)
    wr(REG_DIRECTION, 32'hFF);
    extEn  <= 3'b111;
    extVal <= 3'b011;
    tick(4);
    `CHECK(pinOeN, 3'b111)
    rdchk(REG_PIN_VALUE, 32'h60, 0);
    $display("test port done");
  endtask

  task automatic t_mem();
    extEn <= 3'b000;
    wr(REG_CONTROL, 32'h0F);
    // Direction set to drive, so a released pin proves it is ignored
    wr(REG_DIRECTION, 32'h00);
    memDrv <= 1'b1;
    memAd  <= 3'b101;
    pspRd  <= 1'b1;
    twData <= 1'b0;
    tick(3);
    `CHECK(pinOut, 3'b101)
    `CHECK(pinOeN, 3'b000)
    memDrv <= 1'b0;
    memRd  <= 1'b1;
    pspRd  <= 1'b0;
    twData <= 1'b1;
    extEn  <= 3'b111;
    extVal <= 3'b110;
    tick(3);
    `CHECK(pinOeN, 3'b111)
    `CHECK(memDataIn, 3'b110)
    memRd  <= 1'b0;
    extVal <= 3'b001;
    tick(3);
    `CHECK(memDataIn, 3'b110)
    $display("test memory done");
  endtask

  task automatic t_psp();
    extEn <= 3'b000;
    wr(REG_CONTROL, 32'h02);
    wr(REG_LATCH, 32'h60);
    wr(REG_DIRECTION, 32'h00);
    pspRd <= 1;
    tick(3);
    `CHECK(pinOut, 3'b011)
    `CHECK(pinOeN, 3'b000)
    pspRd <= 0;
    tick(3);
    `CHECK(pinOeN, 3'b111)
    pspWr  <= 1'b1;
    extEn  <= 3'b111;
    extVal <= 3'b101;
    tick(3);
    `CHECK(pspWriteData, 3'b101)
    pspWr <= 0;
    $display("test parallel done");
  endtask

  task automatic t_spi();
    wr(REG_CONTROL, 32'h04);
    wr(REG_DIRECTION, 32'hFF);
    extVal <= 3'b011;
    tick(3);
    `CHECK(serialDataIn, 1'b1)
    `CHECK(serialClockIn, 1'b1)
    `CHECK(slaveSelectInN, 1'b0)
    extVal <= 3'b100;
    tick(3);
    `CHECK({slaveSelectInN, serialClockIn, serialDataIn}, 3'b100)
    extEn <= 3'b000;
    wr(REG_CONTROL, 32'h06);
    wr(REG_LATCH, 32'h00);
    wr(REG_DIRECTION, 32'hBF);
    pspRd  <= 1'b1;
    spiClk <= 1'b1;
    tick(3);
    `CHECK(pinOut, 3'b010)
    `CHECK(pinOeN, 3'b000)
    `CHECK(serialClockIn, 1'b0)
    pspRd  <= 1'b0;
    spiClk <= 1'b0;
    $display("test spi done");
  endtask

  task automatic t_i2c();
    wr(REG_CONTROL, 32'h0E);
    wr(REG_LATCH, 32'hE0);
    wr(REG_DIRECTION, 32'h00);
    pspRd  <= 1'b1;
    twData <= 1'b0;
    twClk  <= 1'b1;
    extEn  <= 3'b010;
    extVal <= 3'b000;
    tick(3);
    `CHECK(pinOut[0], 1'b0)
    `CHECK(pinOeN, 3'b010)
    `CHECK(pinOut[2], 1'b1)
    `CHECK(twoWireClockIn, 1'b0)
    `CHECK(pinInType[0], IN_I2C)
    `CHECK(twoWireDataIn, 1'b0)
    // Owner codes per pin: pin7 parallel, pins 6 and 5 serial
    rdchk(REG_OWNER, 32'h2F, 0);
    wr(REG_CONTROL, 32'h1E);
    tick(3);
    `CHECK(pinInType[1], IN_SMB)
    pspRd  <= 1'b0;
    twData <= 1'b1;
    extEn  <= 3'b000;
    $display("test two wire done");
  endtask

  initial begin
    #100000;
    mismatches++;
    $display("mismatch t=%0t watchdog", $time);
    final_report();
  end

  initial begin
    tick(20);
    reset <= 0;
    tick(2);
    t_reset();
    t_port();
    t_mem();
    t_psp();
    t_spi();
    t_i2c();
    final_report();
  end
endmodule // pdm_pin_mux_test
